/* File: core/iep_pkg.sv */
// constants, register map and carrier types for the interrupt enable/priority bank
package iep_pkg;

	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;

	// word offsets on the register port
	localparam logic [3:0] OFS_ENABLE_1 = 4'h0;
	localparam logic [3:0] OFS_ENABLE_2 = 4'h1;
	localparam logic [3:0] OFS_ENABLE_3 = 4'h2;
	localparam logic [3:0] OFS_ENABLE_4 = 4'h3;
	localparam logic [3:0] OFS_PRIORITY_0 = 4'h4;
	localparam logic [3:0] OFS_IRQ_STATUS = 4'h5;
	localparam logic [3:0] OFS_IRQ_CLEAR = 4'h6;
	localparam logic [3:0] OFS_IRQ_ENABLE = 4'h7;

	// implemented bits of each register
	localparam logic [15:0] MASK_ENABLE_1 = 16'h0007;
	localparam logic [15:0] MASK_ENABLE_2 = 16'h601f;
	localparam logic [15:0] MASK_ENABLE_3 = 16'he600;
	localparam logic [15:0] MASK_ENABLE_4 = 16'hce7e;
	localparam logic [15:0] MASK_PRIORITY_0 = 16'h7777;
	localparam logic [3:0] MASK_IRQ = 4'hf;

	// values after reset
	localparam logic [15:0] RESET_ENABLE = 16'h0000;
	localparam logic [15:0] RESET_PRIORITY_0 = 16'h4444;
	localparam logic [3:0] RESET_IRQ = 4'h0;

	// bits that die on variants without the optional peripherals
	localparam logic [15:0] CAN_BITS_ENABLE_2 = 16'h000c;
	localparam logic [15:0] CAN_BITS_ENABLE_4 = 16'h0040;
	localparam logic [15:0] AUDIO_BITS_ENABLE_4 = 16'hc000;

	// priority field order: index 0 external irq zero, 1 capture, 2 compare, 3 timer
	localparam int PRI_FIELDS = 4;
	localparam int PRI_FIELD_W = 3;
	localparam logic [2:0] PRI_OFF = 3'h0;
	localparam logic [2:0] PRI_TOP = 3'h7;
	localparam logic [2:0] PRI_LOW = 3'h1;

	// status bit positions
	localparam int ST_REQ_RISE = 0;
	localparam int ST_RESV_WRITE = 1;
	localparam int ST_UNMAPPED = 2;
	localparam int ST_PRI_BLOCK = 3;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} iep_bus_t;

	typedef struct packed {
		logic [15:0] e1;
		logic [15:0] e2;
		logic [15:0] e3;
		logic [15:0] e4;
	} iep_src_t;

	typedef struct packed {
		logic [15:0] en1;
		logic [15:0] en2;
		logic [15:0] en3;
		logic [15:0] en4;
		logic [15:0] pri0;
		iep_src_t req;
		logic [3:0] status;
		logic [3:0] mask;
		logic [15:0] rdata;
		logic irq;
		logic best_valid;
		logic [2:0] best_level;
		logic [1:0] best_src;
	} iep_state_t;

	function automatic logic [2:0] iep_pri_field(input logic [15:0] r, input logic [1:0] idx);
		logic [15:0] sh;
		sh = r >> {idx, 2'b00};
		return sh[2:0];
	endfunction

endpackage

/* File: core/iep_regs.sv */
// interrupt enable and priority register bank with request gating
//
// Functional notes
// RQ1: enable bit one passes its source request; zero blocks it.
// RQ2: unimplemented bits read zero and ignore writes.
// RQ3: priority field 111 gives level 7, the highest.
// RQ4: field 001 gives level 1, lowest; others map to binary value.
// RQ5: field 000 disables the source whatever its enable bit.
// RQ6: priority_0 fields at 14-12,10-8,6-4,2-0, each resetting to 100.
// RQ7: enable_1 bits 2,1,0 gate comparator, i2c master, i2c slave.
// RQ8: enable_2: dma4 bit 14, parallel port 13, dma3/can/spi bits 4-0.
// RQ9: enable_3: bits 15,14,13,10,9 implemented; 12-11 and low byte not.
// RQ10: enable_4 upper: audio 15,14; encoder/pwm 11,10,9; 13-12, 8-7 absent.
// RQ11: enable_4 lower: can tx 6, dma7/6 at 5/4, crc 3, uarts 2/1.
// RQ12: without can, can event, receive and transmit requests stay blocked.
// RQ13: without audio converter, left and right requests stay blocked.
// RQ14: implemented enable bits are read/write and clear on reset.
// RQ15: request presented only with flag, enable and nonzero priority.
// RQ16: each register is one 16-bit word; writes land at next edge.
`timescale 1ns/100ps

module iep_regs
	import iep_pkg::*;
#(
	parameter int HAS_CAN = 1,
	parameter int HAS_AUDIO = 1
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// register port
	input wire iep_bus_t bus,
	output logic [DATA_W-1:0] rdata,
	// source flags, same clock domain
	input wire iep_src_t src_flag,
	input wire logic [PRI_FIELDS-1:0] pri_flag,
	input wire logic [PRI_FIELDS-1:0] pri_enable,
	// gated requests and arbitration result
	output iep_src_t req,
	output logic best_valid,
	output logic [2:0] best_level,
	output logic [1:0] best_src,
	// interrupt
	output logic irq
);

	if (HAS_CAN < 0 || HAS_CAN > 1) begin : g_chk_can
		$error("HAS_CAN must be 0 or 1");
	end
	if (HAS_AUDIO < 0 || HAS_AUDIO > 1) begin : g_chk_audio
		$error("HAS_AUDIO must be 0 or 1");
	end

	// absent peripherals are cut at the gate, so stray enable bits stay harmless
	localparam logic [15:0] CAP_2 = (HAS_CAN == 1) ? 16'hffff : ~CAN_BITS_ENABLE_2;
	localparam logic [15:0] CAP_4 = ((HAS_CAN == 1) ? 16'hffff : ~CAN_BITS_ENABLE_4)
		& ((HAS_AUDIO == 1) ? 16'hffff : ~AUDIO_BITS_ENABLE_4);

	iep_state_t st;
	iep_state_t next_st;
	logic mapped;
	logic resv_write;
	logic pri_block;
	logic [2:0] lvl;

	always_comb begin
		next_st = st;
		mapped = (bus.addr <= OFS_IRQ_ENABLE);
		resv_write = 1'b0;
		pri_block = 1'b0;
		lvl = PRI_OFF;

		if (bus.wr) begin
			case (bus.addr)
				OFS_ENABLE_1: begin
					next_st.en1 = bus.wdata & MASK_ENABLE_1; // RQ7 RQ2 RQ16
					resv_write = |(bus.wdata & ~MASK_ENABLE_1);
				end
				OFS_ENABLE_2: begin
					next_st.en2 = bus.wdata & MASK_ENABLE_2; // RQ8 RQ14
					resv_write = |(bus.wdata & ~MASK_ENABLE_2);
				end
				OFS_ENABLE_3: begin
					next_st.en3 = bus.wdata & MASK_ENABLE_3; // RQ9
					resv_write = |(bus.wdata & ~MASK_ENABLE_3);
				end
				OFS_ENABLE_4: begin
					next_st.en4 = bus.wdata & MASK_ENABLE_4; // RQ10 RQ11
					resv_write = |(bus.wdata & ~MASK_ENABLE_4);
				end
				OFS_PRIORITY_0: begin
					next_st.pri0 = bus.wdata & MASK_PRIORITY_0; // RQ6 RQ2
					resv_write = |(bus.wdata & ~MASK_PRIORITY_0);
				end
				OFS_IRQ_ENABLE: begin
					next_st.mask = bus.wdata[3:0] & MASK_IRQ;
				end
				default: begin
				end
			endcase
		end

		// read data valid the cycle after the strobe only
		next_st.rdata = '0;
		if (bus.rd) begin
			case (bus.addr)
				OFS_ENABLE_1: next_st.rdata = st.en1; // RQ2
				OFS_ENABLE_2: next_st.rdata = st.en2;
				OFS_ENABLE_3: next_st.rdata = st.en3;
				OFS_ENABLE_4: next_st.rdata = st.en4;
				OFS_PRIORITY_0: next_st.rdata = st.pri0;
				OFS_IRQ_STATUS: next_st.rdata = {12'h000, st.status};
				OFS_IRQ_ENABLE: next_st.rdata = {12'h000, st.mask};
				default: next_st.rdata = '0;
			endcase
		end

		// gating uses the stored enables, so a write shows one edge later
		next_st.req.e1 = src_flag.e1 & st.en1 & MASK_ENABLE_1; // RQ1
		next_st.req.e2 = src_flag.e2 & st.en2 & MASK_ENABLE_2 & CAP_2; // RQ1 RQ12
		next_st.req.e3 = src_flag.e3 & st.en3 & MASK_ENABLE_3;
		next_st.req.e4 = src_flag.e4 & st.en4 & MASK_ENABLE_4 & CAP_4; // RQ12 RQ13

		// highest level wins; on a tie the lower field index wins
		next_st.best_valid = 1'b0;
		next_st.best_level = PRI_OFF;
		next_st.best_src = 2'b00;
		for (int i = 0; i < PRI_FIELDS; i++) begin
			lvl = iep_pri_field(st.pri0, 2'(i)); // RQ3 RQ4
			if (pri_flag[i] && pri_enable[i]) begin
				if (lvl == PRI_OFF) begin
					pri_block = 1'b1; // RQ5
				end else if (!next_st.best_valid || lvl > next_st.best_level) begin
					next_st.best_valid = 1'b1; // RQ15
					next_st.best_level = lvl;
					next_st.best_src = 2'(i);
				end
			end
		end

		// set beats clear when both land in one cycle
		if (bus.wr && bus.addr == OFS_IRQ_CLEAR) begin
			next_st.status = st.status & ~bus.wdata[3:0];
		end
		next_st.status[ST_REQ_RISE] = next_st.status[ST_REQ_RISE]
			| ((|next_st.req) & ~(|st.req));
		next_st.status[ST_RESV_WRITE] = next_st.status[ST_RESV_WRITE] | resv_write;
		next_st.status[ST_UNMAPPED] = next_st.status[ST_UNMAPPED]
			| ((bus.wr | bus.rd) & ~mapped);
		next_st.status[ST_PRI_BLOCK] = next_st.status[ST_PRI_BLOCK] | pri_block;
		next_st.irq = |(next_st.status & next_st.mask);
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			st <= '0;
			st.en1 <= RESET_ENABLE; // RQ14
			st.en2 <= RESET_ENABLE;
			st.en3 <= RESET_ENABLE;
			st.en4 <= RESET_ENABLE;
			st.pri0 <= RESET_PRIORITY_0; // RQ6
			st.status <= RESET_IRQ;
			st.mask <= RESET_IRQ;
		end else begin
			st <= next_st;
		end
	end

	assign rdata = st.rdata;
	assign req = st.req;
	assign best_valid = st.best_valid;
	assign best_level = st.best_level;
	assign best_src = st.best_src;
	assign irq = st.irq;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	property p_gate_block;
		(st.en3 == 16'h0000 && !(bus.wr && bus.addr == OFS_ENABLE_3)) |=>
			(st.req.e3 == 16'h0000);
	endproperty
	a_gate_block: assert property (p_gate_block) // RQ1
		else $error("request passed with enable cleared");

	property p_gate_pass;
		(src_flag.e1[2] && st.en1[2]) |=> st.req.e1[2];
	endproperty
	a_gate_pass: assert property (p_gate_pass) // RQ1
		else $error("enabled comparator request not passed");

	property p_unimpl_read;
		(bus.rd && bus.addr == OFS_ENABLE_4) |=> ((st.rdata & ~MASK_ENABLE_4) == 16'h0000);
	endproperty
	a_unimpl_read: assert property (p_unimpl_read) // RQ2
		else $error("unimplemented bit read as one");

	property p_pri_top;
		(pri_flag[3] && pri_enable[3] && st.pri0[14:12] == PRI_TOP) |=>
			(best_valid && best_level == 3'h7);
	endproperty
	a_pri_top: assert property (p_pri_top) // RQ3
		else $error("level 7 not granted");

	property p_pri_low;
		(st.pri0 == 16'h1111 && (|(pri_flag & pri_enable))) |=>
			(best_valid && best_level == 3'h1);
	endproperty
	a_pri_low: assert property (p_pri_low) // RQ4
		else $error("level 1 not granted");

	property p_pri_zero;
		(st.pri0 == 16'h0000) |=> !best_valid;
	endproperty
	a_pri_zero: assert property (p_pri_zero) // RQ5
		else $error("source with priority 000 presented");

	property p_reset_pri;
		$past(rst) |-> (st.pri0 == RESET_PRIORITY_0 && st.en2 == RESET_ENABLE);
	endproperty
	a_reset_pri: assert property (p_reset_pri) // RQ6
		else $error("wrong values after reset");

	property p_can_off;
		(HAS_CAN == 0) |-> (st.req.e2[3:2] == 2'b00 && st.req.e4[6] == 1'b0);
	endproperty
	a_can_off: assert property (p_can_off) // RQ12
		else $error("can request passed on variant without can");

	property p_audio_off;
		(HAS_AUDIO == 0) |-> (st.req.e4[15:14] == 2'b00);
	endproperty
	a_audio_off: assert property (p_audio_off) // RQ13
		else $error("audio request passed on variant without audio");

	property p_write_next;
		(bus.wr && bus.addr == OFS_ENABLE_2) |=>
			(st.en2 == ($past(bus.wdata) & MASK_ENABLE_2));
	endproperty
	a_write_next: assert property (p_write_next) // RQ14
		else $error("enable write not stored at next edge");

	property p_read_word;
		(bus.rd && bus.addr == OFS_PRIORITY_0 && !bus.wr) |=> (rdata == $past(st.pri0));
	endproperty
	a_read_word: assert property (p_read_word) // RQ16
		else $error("priority read data wrong");

	property p_present;
		best_valid |-> $past(|(pri_flag & pri_enable));
	endproperty
	a_present: assert property (p_present) // RQ15
		else $error("request presented without flag and enable");

	// register port: each enable and priority write lands, masked to its implemented bits, at the next edge
	property p_write_e1;
		(bus.wr && bus.addr == OFS_ENABLE_1) |=>
			(st.en1 == ($past(bus.wdata) & MASK_ENABLE_1));
	endproperty
	a_write_e1: assert property (p_write_e1) // RQ7
		else $error("enable_1 write not stored");

	property p_write_e3;
		(bus.wr && bus.addr == OFS_ENABLE_3) |=>
			(st.en3 == ($past(bus.wdata) & MASK_ENABLE_3));
	endproperty
	a_write_e3: assert property (p_write_e3) // RQ9
		else $error("enable_3 write not stored");

	property p_write_e4;
		(bus.wr && bus.addr == OFS_ENABLE_4) |=>
			(st.en4 == ($past(bus.wdata) & MASK_ENABLE_4));
	endproperty
	a_write_e4: assert property (p_write_e4) // RQ10 RQ11
		else $error("enable_4 write not stored");

	property p_write_pri;
		(bus.wr && bus.addr == OFS_PRIORITY_0) |=>
			(st.pri0 == ($past(bus.wdata) & MASK_PRIORITY_0));
	endproperty
	a_write_pri: assert property (p_write_pri) // RQ6
		else $error("priority_0 write not stored");

	property p_read_en2;
		(bus.rd && !bus.wr && bus.addr == OFS_ENABLE_2) |=>
			(rdata == $past(st.en2));
	endproperty
	a_read_en2: assert property (p_read_en2) // RQ8
		else $error("enable_2 read data wrong");

	// read data is a one-cycle pulse; idle cycles show zero
	property p_read_idle;
		!bus.rd |=> (rdata == 16'h0000);
	endproperty
	a_read_idle: assert property (p_read_idle) // RQ16
		else $error("read data outside the read cycle");

	// unimplemented positions never hold a one, and writing a one to them in an enable or priority word is logged
	property p_unimpl_store;
		((st.en1 & ~MASK_ENABLE_1) | (st.en2 & ~MASK_ENABLE_2) | (st.en3 & ~MASK_ENABLE_3)
			| (st.en4 & ~MASK_ENABLE_4) | (st.pri0 & ~MASK_PRIORITY_0)) == 16'h0000;
	endproperty
	a_unimpl_store: assert property (p_unimpl_store) // RQ2
		else $error("unimplemented bit stored as one");

	property p_resv_flag;
		(bus.wr && bus.addr == OFS_ENABLE_3 && (bus.wdata & ~MASK_ENABLE_3) != 16'h0000) |=>
			st.status[ST_RESV_WRITE];
	endproperty
	a_resv_flag: assert property (p_resv_flag) // RQ2
		else $error("write to unimplemented bits not logged");

	property p_unmapped;
		((bus.rd || bus.wr) && bus.addr > OFS_IRQ_ENABLE) |=>
			(rdata == 16'h0000 && st.status[ST_UNMAPPED]);
	endproperty
	a_unmapped: assert property (p_unmapped) // RQ2
		else $error("unmapped access not refused");

	property p_read_status;
		(bus.rd && bus.addr == OFS_IRQ_STATUS) |=>
			(rdata[15:4] == 12'h000 && rdata[3:0] == $past(st.status));
	endproperty
	a_read_status: assert property (p_read_status) // RQ2
		else $error("status read data wrong");

	// gating of one source from each of the other enable words
	property p_gate_bits;
		(src_flag.e2[14] && st.en2[14] && src_flag.e3[15] && st.en3[15]
			&& src_flag.e4[3] && st.en4[3]) |=>
			(st.req.e2[14] && st.req.e3[15] && st.req.e4[3]);
	endproperty
	a_gate_bits: assert property (p_gate_bits) // RQ8 RQ9 RQ11
		else $error("enabled request not passed");

	// arbitration: the winner is never below a flagged nonzero field
	property p_pri_level;
		(pri_flag[0] && pri_enable[0] && st.pri0[2:0] != PRI_OFF) |=>
			(best_valid && best_level >= $past(st.pri0[2:0]));
	endproperty
	a_pri_level: assert property (p_pri_level) // RQ4
		else $error("winner below a flagged level");

	property p_pri_block;
		(pri_flag[0] && pri_enable[0] && st.pri0[2:0] == PRI_OFF) |=>
			st.status[ST_PRI_BLOCK];
	endproperty
	a_pri_block: assert property (p_pri_block) // RQ5
		else $error("blocked source not logged");

	property p_best_none;
		((pri_flag & pri_enable) == 4'h0) |=>
			(!best_valid && best_level == PRI_OFF && best_src == 2'b00);
	endproperty
	a_best_none: assert property (p_best_none) // RQ15
		else $error("request presented with no source flagged");

	// status bits only fall through the clear register
	property p_sticky;
		!(bus.wr && bus.addr == OFS_IRQ_CLEAR) |=>
			((st.status & $past(st.status)) == $past(st.status));
	endproperty
	a_sticky: assert property (p_sticky) // RQ15
		else $error("status bit fell without a clear");

	property p_reset_out;
		$past(rst) |-> (rdata == 16'h0000 && req == '0 && !best_valid && !irq
			&& st.en1 == RESET_ENABLE && st.en3 == RESET_ENABLE && st.en4 == RESET_ENABLE);
	endproperty
	a_reset_out: assert property (p_reset_out) // RQ14
		else $error("outputs or enables not clear after reset");

	c_top_grant: cover property (pri_flag[3] && pri_enable[3] ##1 best_level == 3'h7);
	c_irq: cover property ($rose(irq));
	c_clear_race: cover property (bus.wr && bus.addr == OFS_IRQ_CLEAR && pri_block);
	c_gated: cover property ($rose(|st.req.e4));
	c_tie_low: cover property (st.pri0 == 16'h1111 && pri_flag == 4'hf && pri_enable == 4'hf);

endmodule // iep_regs

/* File: verification/test_iep_regs.sv */
// self-checking bench for the interrupt enable and priority bank
`timescale 1ns/100ps

module test_iep_regs
	import iep_pkg::*;
;
	// clock, reset and stimulus
	logic clock = 1'b0;
	logic rst = 1'b1;
	iep_bus_t bus = '0;
	iep_src_t src_flag = '0;
	logic [3:0] pri_flag = 4'h0;
	logic [3:0] pri_enable = 4'h0;
	// observed outputs
	logic [15:0] rdata;
	iep_src_t req;
	iep_src_t req_cut;
	logic best_valid;
	logic [2:0] best_level;
	logic [1:0] best_src;
	logic irq;
	int errors = 0;
	int num_checks = 0;
	logic [15:0] val;
	localparam logic [15:0] REG_MASK [5] = '{MASK_ENABLE_1, MASK_ENABLE_2, MASK_ENABLE_3,
		MASK_ENABLE_4, MASK_PRIORITY_0};
	localparam logic [15:0] PRI_VAL [6] = '{16'h7123, 16'h1111, 16'h0001, 16'h0000,
		16'h0550, 16'h3210};
	// expected {valid, level, winner index}; ties go to the lower index
	localparam logic [5:0] PRI_EXP [6] = '{6'h3f, 6'h24, 6'h24, 6'h00, 6'h35, 6'h2f};

	always #12.5 clock = ~clock;

	iep_regs dut (
		.clock(clock),
		.rst(rst),
		.bus(bus),
		.rdata(rdata),
		.src_flag(src_flag),
		.pri_flag(pri_flag),
		.pri_enable(pri_enable),
		.req(req),
		.best_valid(best_valid),
		.best_level(best_level),
		.best_src(best_src),
		.irq(irq)
	);

	// variant without the optional peripherals, fed the same stimulus
	iep_regs #(
		.HAS_CAN(0),
		.HAS_AUDIO(0)
	) cut (
		.clock(clock),
		.rst(rst),
		.bus(bus),
		.rdata(),
		.src_flag(src_flag),
		.pri_flag(pri_flag),
		.pri_enable(pri_enable),
		.req(req_cut),
		.best_valid(),
		.best_level(),
		.best_src(),
		.irq()
	);

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		num_checks = num_checks + 1;
		if (seen !== exp) begin
			errors = errors + 1;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clock);
		bus.addr <= a;
		bus.wdata <= d;
		bus.wr <= 1'b1;
		@(posedge clock);
		bus.wr <= 1'b0;
	endtask

	// read data stands only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge clock);
		bus.addr <= a;
		bus.rd <= 1'b1;
		@(posedge clock);
		bus.rd <= 1'b0;
		#1;
		d = rdata;
	endtask

	// enable writes reach the gated outputs two cycles after the strobe
	task automatic settle;
		repeat (3) @(posedge clock);
		#1;
	endtask

	task automatic complete_run;
		if (errors == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	initial begin
		#(2000 * 25);
		errors = errors + 1;
		complete_run;
	end

	initial begin
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		for (int i = 0; i < 5; i++) begin
			rd(4'(i), val);
			chk(val, (i == 4) ? RESET_PRIORITY_0 : RESET_ENABLE);
		end
		for (int i = 0; i < 5; i++) begin
			wr(4'(i), 16'hffff);
			rd(4'(i), val);
			chk(val, REG_MASK[i]);
		end
		wr(4'h9, 16'h1234);
		rd(4'h9, val);
		chk(val, 16'h0000);
		rd(OFS_IRQ_STATUS, val);
		chk(val, 16'h0006);
		wr(OFS_IRQ_CLEAR, 16'h000f);
		rd(OFS_IRQ_STATUS, val);
		chk(val, 16'h0000);
		rd(OFS_IRQ_CLEAR, val);
		chk(val, 16'h0000);
		// all sources flagged, all enables set
		@(posedge clock);
		src_flag <= '1;
		settle;
		chk(req.e1, MASK_ENABLE_1);
		chk(req.e2, MASK_ENABLE_2);
		chk(req.e3, MASK_ENABLE_3);
		chk(req.e4, MASK_ENABLE_4);
		chk(req_cut.e2, MASK_ENABLE_2 & ~CAN_BITS_ENABLE_2);
		chk(req_cut.e4, MASK_ENABLE_4 & ~(CAN_BITS_ENABLE_4 | AUDIO_BITS_ENABLE_4));
		wr(OFS_IRQ_ENABLE, 16'h0001);
		settle;
		chk({15'h0000, irq}, 16'h0001);
		wr(OFS_IRQ_ENABLE, 16'h0000);
		settle;
		chk({15'h0000, irq}, 16'h0000);
		// status stays sticky while masked; a clear drops the line
		rd(OFS_IRQ_STATUS, val);
		chk(val, 16'h0001);
		wr(OFS_IRQ_ENABLE, 16'h0001);
		wr(OFS_IRQ_CLEAR, 16'h0001);
		settle;
		chk({15'h0000, irq}, 16'h0000);
		for (int i = 0; i < 4; i++) begin
			wr(4'(i), 16'h0000);
		end
		settle;
		chk(req.e1 | req.e2 | req.e3 | req.e4, 16'h0000);
		// priority fields against all four flagged and enabled sources
		@(posedge clock);
		pri_flag <= 4'hf;
		pri_enable <= 4'hf;
		wr(OFS_IRQ_CLEAR, 16'h000f);
		for (int i = 0; i < 6; i++) begin
			wr(OFS_PRIORITY_0, PRI_VAL[i]);
			settle;
			chk({10'h000, best_valid, best_level, best_src}, {10'h000, PRI_EXP[i]});
		end
		rd(OFS_IRQ_STATUS, val);
		chk(val & 16'h0008, 16'h0008);
		// last blocked cycle meets the clear strobe, so the set must win
		wr(OFS_IRQ_CLEAR, 16'h0008);
		pri_enable <= 4'h0;
		rd(OFS_IRQ_STATUS, val);
		chk(val & 16'h0008, 16'h0008);
		wr(OFS_IRQ_CLEAR, 16'h0008);
		rd(OFS_IRQ_STATUS, val);
		chk(val & 16'h0008, 16'h0000);
		wr(OFS_PRIORITY_0, 16'h7777);
		settle;
		chk({15'h0000, best_valid}, 16'h0000);
		complete_run;
	end

endmodule // test_iep_regs
